//--- src/tcc_defines.svh
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH

// ============================================================
// register offsets
`define TCC_OFF_CSR        4'h0
`define TCC_OFF_CAP1_HI    4'h1
`define TCC_OFF_CAP1_LO    4'h2
`define TCC_OFF_CMP1_HI    4'h3
`define TCC_OFF_CMP1_LO    4'h4
`define TCC_OFF_CMP2_HI    4'h5
`define TCC_OFF_CMP2_LO    4'h6
`define TCC_OFF_CNT_HI     4'h7
`define TCC_OFF_CNT_LO     4'h8
`define TCC_OFF_ALT_HI     4'h9
`define TCC_OFF_ALT_LO     4'ha
`define TCC_OFF_CAP2_HI    4'hb
`define TCC_OFF_CAP2_LO    4'hc
`define TCC_OFF_IRQ_STAT   4'hd
`define TCC_OFF_IRQ_MASK   4'he

// ============================================================
// control/status field positions
`define TCC_CSR_CAP1       7
`define TCC_CSR_CMP1       6
`define TCC_CSR_OVF        5
`define TCC_CSR_CAP2       4
`define TCC_CSR_CMP2       3
`define TCC_CSR_TIMD       2

// ============================================================
// reset values and counter constants
`define TCC_RST_BYTE       8'h00
`define TCC_RST_CMP2_HI    8'h80
`define TCC_RST_IRQ        5'h00
`define TCC_CNT_RESTART    16'h0000
`define TCC_CNT_ALL_ONES   16'hffff
`define TCC_PRESC_LAST     2'h3

`endif

//--- src/tcc_pkg.sv
package tcc_pkg;

    typedef logic [7:0]  tcc_byte_t;
    typedef logic [15:0] tcc_word_t;
    typedef logic [3:0]  tcc_addr_t;

    // event bits, one-hot, same layout in interrupt status and mask
    typedef enum logic [4:0]
    {
        TCC_EV_CAP1 = 5'b00001,
        TCC_EV_CMP1 = 5'b00010,
        TCC_EV_OVF  = 5'b00100,
        TCC_EV_CAP2 = 5'b01000,
        TCC_EV_CMP2 = 5'b10000
    } tcc_event_t;

endpackage

//--- src/tcc_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defines.svh"

module tcc_timer
    import tcc_pkg::*;
(
    input  wire logic      clk,              // 200 MHz clock
    input  wire logic      reset,            // async reset, active high
    input  wire tcc_addr_t reg_addr,         // register offset
    input  wire tcc_byte_t reg_wdata,        // write data
    input  wire logic      reg_wr,           // write strobe
    input  wire logic      reg_rd,           // read strobe
    output tcc_byte_t      reg_rdata,        // read data, cycle after strobe
    input  wire logic      capture_one_pin,  // capture input one, async
    input  wire logic      capture_two_pin,  // capture input two, async
    output logic           compare_one_out,  // compare one match level
    output logic           compare_two_out,  // compare two match level
    output logic           irq               // level interrupt
);

    // ============================================================
    // helpers
    // true when a strobe hits the given offset
    function automatic logic hit(input logic strobe, input tcc_addr_t a,
                                 input tcc_addr_t off);
        hit = strobe && (a == off);
    endfunction

    // merge a hardware set with a software clear, set wins
    function automatic logic flag_next(input logic cur, input logic set,
                                       input logic clr);
        flag_next = set | (cur & ~clr);
    endfunction

    // ============================================================
    // state
    tcc_word_t counter_r;
    logic [1:0] presc_r;
    logic       tick;
    logic       restart;
    logic       wrap;
    logic       check_r;
    tcc_byte_t  capture_one_high_r;
    tcc_byte_t  capture_one_low_r;
    tcc_byte_t  capture_two_high_r;
    tcc_byte_t  capture_two_low_r;
    tcc_byte_t  compare_one_high_r;
    tcc_byte_t  compare_one_low_r;
    tcc_byte_t  compare_two_high_r;
    tcc_byte_t  compare_two_low_r;
    logic       timer_disable_r;
    logic       cap1_flag_r;
    logic       compare_one_flag_r;
    logic       overflow_flag_r;
    logic       cap2_flag_r;
    logic       cmp2_flag_r;
    logic [4:0] arm_r;
    logic [4:0] irq_stat_r;
    logic [4:0] irq_mask_r;
    logic [4:0] events;
    logic [2:0] cap1_sync_r;
    logic [2:0] cap2_sync_r;
    logic       cap1_ev;
    logic       cap2_ev;
    logic       match1;
    logic       match2;
    logic       acc_cnt_lo;
    logic       acc_alt_lo;
    logic       acc_cmp1_lo;
    logic       acc_cmp2_lo;
    logic       acc_cap1_lo;
    logic       acc_cap2_lo;
    logic       csr_rd;
    tcc_byte_t  csr_val;
    tcc_byte_t  rdata_nxt;

    // ============================================================
    // register access decode
    // a low byte access is either a read or a write
    assign acc_cnt_lo  = hit(reg_rd | reg_wr, reg_addr, `TCC_OFF_CNT_LO);
    assign acc_alt_lo  = hit(reg_rd | reg_wr, reg_addr, `TCC_OFF_ALT_LO);
    assign acc_cmp1_lo = hit(reg_rd | reg_wr, reg_addr, `TCC_OFF_CMP1_LO);
    assign acc_cmp2_lo = hit(reg_rd | reg_wr, reg_addr, `TCC_OFF_CMP2_LO);
    assign acc_cap1_lo = hit(reg_rd | reg_wr, reg_addr, `TCC_OFF_CAP1_LO);
    assign acc_cap2_lo = hit(reg_rd | reg_wr, reg_addr, `TCC_OFF_CAP2_LO);
    assign csr_rd      = hit(reg_rd, reg_addr, `TCC_OFF_CSR);

    // write to either low counter byte restarts, data ignored
    assign restart = hit(reg_wr, reg_addr, `TCC_OFF_CNT_LO)
                   | hit(reg_wr, reg_addr, `TCC_OFF_ALT_LO);

    // ============================================================
    // prescaler, one enable pulse every four clocks
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            presc_r <= 2'h0;
        else if (restart)
            presc_r <= 2'h0;
        else if (!timer_disable_r)
            presc_r <= presc_r + 2'h1;
    end

    assign tick = !timer_disable_r && (presc_r == `TCC_PRESC_LAST);
    assign wrap = tick && !restart
                  && (counter_r == `TCC_CNT_ALL_ONES);

    // ============================================================
    // free-running counter
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            counter_r <= `TCC_CNT_RESTART;
        else if (restart)
            counter_r <= `TCC_CNT_RESTART;
        else if (tick)
            counter_r <= counter_r + 16'h0001;
    end

    // compare only the cycle after the counter moved, one flag per value
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            check_r <= 1'b0;
        else
            check_r <= tick | restart;
    end

    // both bytes must agree for a match
    assign match1 = check_r && (counter_r ==
                    {compare_one_high_r, compare_one_low_r});
    assign match2 = check_r && (counter_r ==
                    {compare_two_high_r, compare_two_low_r});

    // ============================================================
    // capture pin synchronisers and rising edge detect
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cap1_sync_r <= 3'h0;
            cap2_sync_r <= 3'h0;
        end
        else
        begin
            cap1_sync_r <= {cap1_sync_r[1:0], capture_one_pin};
            cap2_sync_r <= {cap2_sync_r[1:0], capture_two_pin};
        end
    end

    assign cap1_ev = cap1_sync_r[1] & ~cap1_sync_r[2];
    assign cap2_ev = cap2_sync_r[1] & ~cap2_sync_r[2];

    // ============================================================
    // capture registers
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            capture_one_high_r <= `TCC_RST_BYTE;
            capture_one_low_r  <= `TCC_RST_BYTE;
            capture_two_high_r <= `TCC_RST_BYTE;
        end
        else
        begin
            if (cap1_ev)
            begin
                capture_one_high_r <= counter_r[15:8];
                capture_one_low_r  <= counter_r[7:0];
            end
            if (cap2_ev)
                capture_two_high_r <= counter_r[15:8];
        end
    end

    // low byte of capture two has no reset on purpose
    always_ff @(posedge clk)
    begin
        if (cap2_ev)
            capture_two_low_r <= counter_r[7:0];
    end

    // ============================================================
    // compare value registers
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            compare_one_high_r <= `TCC_RST_BYTE;
            compare_one_low_r  <= `TCC_RST_BYTE;
            compare_two_high_r <= `TCC_RST_CMP2_HI;
            compare_two_low_r  <= `TCC_RST_BYTE;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                `TCC_OFF_CMP1_HI: compare_one_high_r <= reg_wdata;
                `TCC_OFF_CMP1_LO: compare_one_low_r  <= reg_wdata;
                `TCC_OFF_CMP2_HI: compare_two_high_r <= reg_wdata;
                `TCC_OFF_CMP2_LO: compare_two_low_r  <= reg_wdata;
                default: ;
            endcase
        end
    end

    // ============================================================
    // timer disable bit, freezes prescaler and counter
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            timer_disable_r <= 1'b0;
        else if (hit(reg_wr, reg_addr, `TCC_OFF_CSR))
            timer_disable_r <= reg_wdata[`TCC_CSR_TIMD];
    end

    // ============================================================
    // status flags: armed by a status read, cleared by low byte access
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            arm_r <= 5'h00;
        else if (csr_rd)
            arm_r <= {cmp2_flag_r, cap2_flag_r, overflow_flag_r,
                      compare_one_flag_r, cap1_flag_r};
        else
        begin
            if (acc_cap1_lo) arm_r[0] <= 1'b0;
            if (acc_cmp1_lo) arm_r[1] <= 1'b0;
            if (acc_cnt_lo)  arm_r[2] <= 1'b0;
            if (acc_cap2_lo) arm_r[3] <= 1'b0;
            if (acc_cmp2_lo) arm_r[4] <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cap1_flag_r        <= 1'b0;
            compare_one_flag_r <= 1'b0;
            overflow_flag_r    <= 1'b0;
            cap2_flag_r        <= 1'b0;
            cmp2_flag_r        <= 1'b0;
        end
        else
        begin
            cap1_flag_r        <= flag_next(cap1_flag_r, cap1_ev,
                                            arm_r[0] & acc_cap1_lo);
            compare_one_flag_r <= flag_next(compare_one_flag_r, match1,
                                            arm_r[1] & acc_cmp1_lo);
            // only the main low byte clears, never the alternate one
            overflow_flag_r    <= flag_next(overflow_flag_r, wrap,
                                            arm_r[2] & acc_cnt_lo);
            cap2_flag_r        <= flag_next(cap2_flag_r, cap2_ev,
                                            arm_r[3] & acc_cap2_lo);
            cmp2_flag_r        <= flag_next(cmp2_flag_r, match2,
                                            arm_r[4] & acc_cmp2_lo);
        end
    end

    // ============================================================
    // interrupt status, write one to clear, set wins
    assign events = {match2, cap2_ev, wrap, match1,
                     cap1_ev};

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            irq_stat_r <= `TCC_RST_IRQ;
        else if (hit(reg_wr, reg_addr, `TCC_OFF_IRQ_STAT))
            irq_stat_r <= events | (irq_stat_r & ~reg_wdata[4:0]);
        else
            irq_stat_r <= events | irq_stat_r;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            irq_mask_r <= `TCC_RST_IRQ;
        else if (hit(reg_wr, reg_addr, `TCC_OFF_IRQ_MASK))
            irq_mask_r <= reg_wdata[4:0];
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            irq <= 1'b0;
        else
            irq <= |(irq_stat_r & irq_mask_r);
    end

    // ============================================================
    // compare outputs, registered match levels
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            compare_one_out <= 1'b0;
            compare_two_out <= 1'b0;
        end
        else
        begin
            compare_one_out <= counter_r ==
                               {compare_one_high_r, compare_one_low_r};
            compare_two_out <= counter_r ==
                               {compare_two_high_r, compare_two_low_r};
        end
    end

    // ============================================================
    // read mux, data in the cycle after the strobe

    assign csr_val = {cap1_flag_r, compare_one_flag_r, overflow_flag_r,
                      cap2_flag_r, cmp2_flag_r, timer_disable_r, 2'b00};

    always_comb
    begin
        rdata_nxt = 8'h00;
        unique case (reg_addr)
            `TCC_OFF_CSR:      rdata_nxt = csr_val;
            `TCC_OFF_CAP1_HI:  rdata_nxt = capture_one_high_r;
            `TCC_OFF_CAP1_LO:  rdata_nxt = capture_one_low_r;
            `TCC_OFF_CMP1_HI:  rdata_nxt = compare_one_high_r;
            `TCC_OFF_CMP1_LO:  rdata_nxt = compare_one_low_r;
            `TCC_OFF_CMP2_HI:  rdata_nxt = compare_two_high_r;
            `TCC_OFF_CMP2_LO:  rdata_nxt = compare_two_low_r;
            `TCC_OFF_CNT_HI:   rdata_nxt = counter_r[15:8];
            `TCC_OFF_CNT_LO:   rdata_nxt = counter_r[7:0];
            `TCC_OFF_ALT_HI:   rdata_nxt = counter_r[15:8];
            `TCC_OFF_ALT_LO:   rdata_nxt = counter_r[7:0];
            `TCC_OFF_CAP2_HI:  rdata_nxt = capture_two_high_r;
            `TCC_OFF_CAP2_LO:  rdata_nxt = capture_two_low_r;
            `TCC_OFF_IRQ_STAT: rdata_nxt = {3'b000, irq_stat_r};
            `TCC_OFF_IRQ_MASK: rdata_nxt = {3'b000, irq_mask_r};
            default:           rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rdata_nxt;
        else
            reg_rdata <= 8'h00;
    end

    // ============================================================
    // checks
    a_cap_one_latch: assert property (@(posedge clk)
        disable iff (reset) cap1_ev |=>
        {capture_one_high_r, capture_one_low_r} == $past(counter_r))
        else $error("capture one did not latch the counter");
    a_cap_two_latch: assert property (@(posedge clk)
        disable iff (reset) cap2_ev |=>
        {capture_two_high_r, capture_two_low_r} == $past(counter_r))
        else $error("capture two did not latch the counter");
    a_cmp_one_flag: assert property (@(posedge clk)
        disable iff (reset) (check_r && counter_r ==
        {compare_one_high_r, compare_one_low_r}) |=> compare_one_flag_r)
        else $error("compare one match did not set its flag");
    a_cmp_two_flag: assert property (@(posedge clk)
        disable iff (reset) (check_r && !cmp2_flag_r
        && counter_r[15:8] != compare_two_high_r) |=> !cmp2_flag_r)
        else $error("compare two flag set with high byte unequal");
    a_cnt_read: assert property (@(posedge clk)
        disable iff (reset) (reg_rd && reg_addr == `TCC_OFF_CNT_LO)
        |=> reg_rdata == $past(counter_r[7:0]))
        else $error("counter low read returned wrong byte");
    a_alt_read: assert property (@(posedge clk)
        disable iff (reset) (reg_rd && reg_addr == `TCC_OFF_ALT_HI)
        |=> reg_rdata == $past(counter_r[15:8]))
        else $error("alternate counter high read returned wrong byte");
    a_restart_cnt: assert property (@(posedge clk)
        disable iff (reset) (reg_wr && (reg_addr == `TCC_OFF_CNT_LO
        || reg_addr == `TCC_OFF_ALT_LO)) |=> counter_r == `TCC_CNT_RESTART)
        else $error("low counter write did not restart the counter");
    a_ovf_clear: assert property (@(posedge clk)
        disable iff (reset) ((csr_rd && overflow_flag_r) ##1
        (acc_cnt_lo && !wrap)) |=> !overflow_flag_r)
        else $error("overflow flag not cleared by counter low access");
    a_alt_keeps_ovf: assert property (@(posedge clk)
        disable iff (reset) (overflow_flag_r && acc_alt_lo)
        |=> overflow_flag_r)
        else $error("alternate counter access cleared overflow flag");
    a_ovf_wrap: assert property (@(posedge clk)
        disable iff (reset) wrap
        |=> (overflow_flag_r && counter_r == `TCC_CNT_RESTART))
        else $error("wrap did not set overflow or reach zero");
    a_cmp_clear: assert property (@(posedge clk)
        disable iff (reset) ((csr_rd && compare_one_flag_r) ##1
        (acc_cmp1_lo && !match1)) |=> !compare_one_flag_r)
        else $error("compare one flag not cleared by low byte access");

endmodule

`default_nettype wire

//--- verification/tcc_pin_drv.sv
`timescale 1ns/1ps
`default_nettype none

// drives the two capture pins, each fire request gives a six-cycle high pulse
module tcc_pin_drv
(
    input  wire logic       clk,      // bench clock
    input  wire logic       reset,    // async reset, active high
    input  wire logic [1:0] fire,     // one-cycle request per pin
    output logic            pin_one,  // capture input one
    output logic            pin_two   // capture input two
);
    logic [2:0] hold_one_r;
    logic [2:0] hold_two_r;

    // hold counters, long enough to pass the pin synchronisers
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            hold_one_r <= 3'h0;
            hold_two_r <= 3'h0;
        end
        else
        begin
            hold_one_r <= fire[0] ? 3'h6 : hold_one_r - (hold_one_r != 3'h0);
            hold_two_r <= fire[1] ? 3'h6 : hold_two_r - (hold_two_r != 3'h0);
        end
    end

    // pins stay low between pulses
    assign pin_one = (hold_one_r != 3'h0);
    assign pin_two = (hold_two_r != 3'h0);
endmodule

`default_nettype wire

//--- verification/test_timer_capture_compare_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defines.svh"

module test_timer_capture_compare_regs
    import tcc_pkg::*;
;
    logic      clk;
    logic      reset;
    logic      reg_wr;
    logic      reg_rd;
    logic      irq;
    logic      pin_one;
    logic      pin_two;
    logic      cmp_one;
    logic      cmp_two;
    logic [1:0] fire;
    tcc_addr_t reg_addr;
    tcc_byte_t reg_wdata;
    tcc_byte_t reg_rdata;
    tcc_byte_t d;
    tcc_byte_t v_hi;
    tcc_byte_t v_lo;
    int        errors;
    int        n_tests;
    int        cyc;

    tcc_timer dut_u (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .capture_one_pin(pin_one),
        .capture_two_pin(pin_two), .compare_one_out(cmp_one),
        .compare_two_out(cmp_two), .irq(irq));

    tcc_pin_drv pins_u (.clk(clk), .reset(reset), .fire(fire),
        .pin_one(pin_one), .pin_two(pin_two));

    // ============================================================
    // clock, 5 ns period
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ============================================================
    // bus tasks
    task automatic wr(input tcc_addr_t a, input tcc_byte_t w);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= w;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input tcc_addr_t a, output tcc_byte_t q);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 q = reg_rdata;
    endtask

    task automatic chk(input string n, input tcc_byte_t e, input tcc_byte_t g);
        n_tests++;
        if (g !== e)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rc(input tcc_addr_t a, input tcc_byte_t e);
        tcc_byte_t q;
        rd(a, q);
        chk($sformatf("reg %h", a), e, q);
    endtask

    task automatic pulse(input logic [1:0] p);
        @(posedge clk);
        fire <= p;
        @(posedge clk);
        fire <= 2'b00;
        repeat (10) @(posedge clk);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ============================================================
    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            errors++;
            $display("ERROR timeout expected done seen hang");
            finish_test();
        end
    end

    // ============================================================
    // test sequence
    initial
    begin
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        fire = 2'b00;
        errors = 0;
        n_tests = 0;
        cyc = 0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rc(`TCC_OFF_CMP2_HI, 8'h80);
        rc(`TCC_OFF_CMP2_LO, 8'h00);
        rc(`TCC_OFF_CMP1_HI, 8'h00);
        rc(`TCC_OFF_CMP1_LO, 8'h00);
        rc(4'hf, 8'h00);
        rc(`TCC_OFF_IRQ_MASK, 8'h00);
        $display("test reset values done");
        // compare bytes read back what was written
        for (int i = 3; i < 7; i++)
            wr(tcc_addr_t'(i), tcc_byte_t'(8'h11 * i));
        for (int i = 3; i < 7; i++)
            rc(tcc_addr_t'(i), tcc_byte_t'(8'h11 * i));
        $display("test compare registers done");
        // freeze, restart through main low byte, written byte not loaded
        wr(`TCC_OFF_CSR, 8'h04);
        wr(`TCC_OFF_CNT_LO, 8'h55);
        rc(`TCC_OFF_CNT_LO, 8'h00);
        rc(`TCC_OFF_CNT_HI, 8'h00);
        rc(`TCC_OFF_ALT_LO, 8'h00);
        $display("test restart done");
        // compare one at 0005, compare two 0105 differs only in high byte
        wr(`TCC_OFF_CMP1_HI, 8'h00);
        wr(`TCC_OFF_CMP1_LO, 8'h05);
        wr(`TCC_OFF_CMP2_HI, 8'h01);
        wr(`TCC_OFF_CMP2_LO, 8'h05);
        wr(`TCC_OFF_IRQ_MASK, 8'h02);
        rd(`TCC_OFF_CSR, d);
        rd(`TCC_OFF_CMP1_LO, d);
        rd(`TCC_OFF_CMP2_LO, d);
        wr(`TCC_OFF_IRQ_STAT, 8'h1f);
        wr(`TCC_OFF_CSR, 8'h00);
        repeat (40) @(posedge clk);
        wr(`TCC_OFF_CSR, 8'h04);
        rd(`TCC_OFF_CSR, d);
        chk("csr flags", 8'h44, d & 8'h4c);
        chk("irq raised", 8'h01, {7'h00, irq});
        rd(`TCC_OFF_CMP1_LO, d);
        rd(`TCC_OFF_CSR, d);
        chk("compare flag clear", 8'h00, d & 8'h40);
        wr(`TCC_OFF_IRQ_STAT, 8'h02);
        repeat (2) @(posedge clk);
        chk("irq cleared", 8'h00, {7'h00, irq});
        $display("test compare match done");
        // ten prescaled ticks ran before the freeze, both ports show 000a
        rd(`TCC_OFF_CNT_HI, v_hi);
        rd(`TCC_OFF_CNT_LO, v_lo);
        chk("counter high", 8'h00, v_hi);
        chk("counter low", 8'h0a, v_lo);
        rc(`TCC_OFF_ALT_HI, 8'h00);
        rc(`TCC_OFF_ALT_LO, 8'h0a);
        // captures latch the frozen value, read-only bytes ignore writes
        pulse(2'b01);
        rc(`TCC_OFF_CAP1_HI, 8'h00);
        rc(`TCC_OFF_CAP1_LO, 8'h0a);
        wr(`TCC_OFF_CAP1_LO, 8'haa);
        rc(`TCC_OFF_CAP1_LO, 8'h0a);
        pulse(2'b10);
        rc(`TCC_OFF_CAP2_HI, 8'h00);
        rc(`TCC_OFF_CAP2_LO, 8'h0a);
        rd(`TCC_OFF_CSR, d);
        chk("capture flags", 8'h90, d & 8'h90);
        rd(`TCC_OFF_CAP1_LO, d);
        rd(`TCC_OFF_CSR, d);
        chk("capture one clear", 8'h10, d & 8'h90);
        rc(`TCC_OFF_IRQ_STAT, 8'h09);
        chk("irq masked", 8'h00, {7'h00, irq});
        $display("test capture done");
        // restart through the alternate low byte
        wr(`TCC_OFF_CSR, 8'h00);
        repeat (20) @(posedge clk);
        wr(`TCC_OFF_CSR, 8'h04);
        wr(`TCC_OFF_ALT_LO, 8'h33);
        rc(`TCC_OFF_ALT_LO, 8'h00);
        rc(`TCC_OFF_CNT_HI, 8'h00);
        $display("test alternate restart done");
        // frozen at zero, compare one moves from 0005 onto the counter
        chk("compare one out low", 8'h00, {7'h00, cmp_one});
        wr(`TCC_OFF_CMP1_LO, 8'h00);
        repeat (2) @(posedge clk);
        chk("compare one out", 8'h01, {7'h00, cmp_one});
        chk("compare two out", 8'h00, {7'h00, cmp_two});
        $display("test compare outputs done");
        finish_test();
    end
endmodule

`default_nettype wire
